// ---- hw/rcw_map.svh ----
// offsets, fields, reset values and codes of the reset sequencer
// assumes word-aligned AHB-Lite access
`ifndef RCW_MAP_SVH
`define RCW_MAP_SVH
// register indices, byte address is four times the index
`define RCW_IDX_STATUS 12'hFCC
`define RCW_IDX_PROTECT 12'hFDF
`define RCW_IDX_CTRL 12'hFE0
`define RCW_IDX_WULEN 12'hFE1
`define RCW_IDX_SEQSTAT 12'hFE2
// status fields
`define RCW_BIT_FCLR 7
`define RCW_BIT_TRIM_ABN 5
// protection code that commits the flag clear
`define RCW_CODE_FCLR 8'h71
// reset values
`define RCW_STATUS_RST 7'h00
`define RCW_WULEN_RST 16'h0100
// cpu start-up state
`define RCW_RESET_VECTOR 16'hFFFE
`define RCW_SP_INIT 16'h00FF
// ahb codes
`define RCW_HTRANS_NONSEQ 2'h2
`define RCW_HSIZE_WORD 3'h2
`endif

// ---- hw/rcw_pkg.sv ----
// types of the reset sequencer
// assumes rcw_map.svh for all numbers
package rcw_pkg;
  typedef enum logic [1:0] {
    RCW_RESET = 2'b00,
    RCW_WARM = 2'b01,
    RCW_RUN = 2'b10
  } rcw_state_t;
  typedef struct packed {
    logic flash;
    logic trim;
    logic vdet_two;
    logic vdet_one;
    logic clock;
    logic watchdog;
  } rcw_req_t;
  typedef struct packed {
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
    logic register_bank_select;
    logic interrupt_master_enable;
    logic irq_enable_clr;
    logic irq_latch_clr;
  } rcw_cpu_init_t;
endpackage : rcw_pkg

// ---- hw/rcw_sequencer.sv ----
// reset cause collection and post-reset warm-up sequencer
// assumes one ahb-lite master, hclk as high-frequency clock,
// reset request and pin inputs asynchronous to hclk
`timescale 1ns/100ps
`include "rcw_map.svh"

module rcw_sequencer
  import rcw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // reset sources
  input wire logic ext_rst_n,
  input wire rcw_req_t rst_req,
  // trimming data from non-volatile storage
  output logic trim_rd_req,
  input wire logic trim_rd_valid,
  input wire logic [7:0] trim_rd_data,
  input wire logic trim_rd_bad,
  output logic [7:0] trim_data,
  // cpu and peripheral control
  output logic cpu_rst_n,
  output logic periph_rst_n,
  output logic cpu_start,
  output rcw_cpu_init_t cpu_init,
  output logic hf_osc_force_en,
  output logic lf_osc_force_dis,
  output logic tg_clear,
  output logic port_hiz,
  output logic watchdog_en,
  output logic vdet_en
);

  // ************************************************************
  // synchronisers
  // ************************************************************
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] sync_in;
  logic pin_rst;
  rcw_req_t req_s;
  logic rst_any;

  assign sync_in = {rst_req, ext_rst_n};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_reg[gi] <= sync_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // synchronisers reset low, so power-on also reads as a held pin and wipes the flags
  assign pin_rst = ~sync2_reg[0];
  assign req_s = sync2_reg[6:1];
  assign rst_any = pin_rst | (|req_s);

  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  logic addr_ok;
  logic acc_wr;
  logic wr_phase_reg;
  logic [11:0] idx_reg;
  logic [11:0] idx_a;
  logic word_ok;
  logic wr_status;
  logic wr_protect;
  logic wr_ctrl;
  logic wr_wulen;
  logic hit_status;
  logic hit_ctrl;
  logic hit_wulen;
  logic hit_seq;

  assign addr_ok = hsel & hready & (htrans == `RCW_HTRANS_NONSEQ);
  assign word_ok = (hsize == `RCW_HSIZE_WORD) & (haddr[1:0] == 2'h0);
  assign acc_wr = addr_ok & hwrite & word_ok;
  assign idx_a = haddr[13:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_phase_reg <= 1'b0;
      idx_reg <= 12'h000;
    end else if (clk_en) begin
      if (hready) begin
        wr_phase_reg <= acc_wr;
      end
      if (addr_ok) begin
        idx_reg <= (haddr[31:14] == 18'h00000) ? idx_a : 12'h000;
      end
    end
  end

  assign hit_status = (idx_reg == `RCW_IDX_STATUS);
  assign hit_ctrl = (idx_reg == `RCW_IDX_CTRL);
  assign hit_wulen = (idx_reg == `RCW_IDX_WULEN);
  assign hit_seq = (idx_reg == `RCW_IDX_SEQSTAT);
  assign wr_status = wr_phase_reg & hit_status;
  assign wr_protect = wr_phase_reg & (idx_reg == `RCW_IDX_PROTECT);
  assign wr_ctrl = wr_phase_reg & hit_ctrl;
  assign wr_wulen = wr_phase_reg & hit_wulen;
  // zero wait states and always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ************************************************************
  // warm-up sequencer
  // ************************************************************
  rcw_state_t state_reg;
  rcw_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] wulen_reg;
  logic trim_done_reg;
  logic trim_done_next;
  logic trim_load;
  logic warm_done;
  logic start_reg;
  logic run;

  assign trim_load = (state_reg == RCW_WARM) & ~trim_done_reg & trim_rd_valid;
  // done needs both the count and a trimming load
  assign warm_done = (state_reg == RCW_WARM) & ~rst_any &
                     (cnt_reg >= wulen_reg) & trim_done_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    trim_done_next = trim_done_reg;
    case (state_reg)
      RCW_RESET: begin
        cnt_next = 16'h0000;
        trim_done_next = 1'b0;
        if (!rst_any) begin
          state_next = RCW_WARM;
        end
      end
      RCW_WARM: begin
        if (rst_any) begin
          state_next = RCW_RESET;
          cnt_next = 16'h0000;
        end else if (warm_done) begin
          state_next = RCW_RUN;
        end else begin
          cnt_next = (cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h0001;
          if (trim_load) begin
            trim_done_next = 1'b1;
          end
        end
      end
      RCW_RUN: begin
        if (rst_any) begin
          state_next = RCW_RESET;
        end
      end
      default: begin
        state_next = RCW_RESET;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= RCW_RESET;
      cnt_reg <= 16'h0000;
      trim_done_reg <= 1'b0;
      start_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      trim_done_reg <= trim_done_next;
      start_reg <= warm_done;
    end
  end

  // ************************************************************
  // trimming data latch
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_data <= 8'h00;
    end else if (clk_en && trim_load) begin
      trim_data <= trim_rd_data;
    end
  end

  assign trim_rd_req = (state_reg == RCW_WARM) & ~trim_done_reg;

  // ************************************************************
  // reset cause status
  // ************************************************************
  logic [6:0] flags_reg;
  logic [6:0] flags_next;
  logic [6:0] flags_set;
  logic fclr_reg;
  logic fclr_next;
  logic commit;
  logic wipe;

  // bit 5 is kept apart, it is a state and not a cause
  assign flags_set = {req_s.flash, 1'b0, req_s.trim, req_s.vdet_two,
                      req_s.vdet_one, req_s.clock, req_s.watchdog};
  assign commit = wr_protect & fclr_reg &
                  (hwdata[7:0] == `RCW_CODE_FCLR);
  assign wipe = pin_rst | commit;

  // set wins over a wipe in the same cycle, so no cause is lost
  always_comb begin
    flags_next = wipe ? `RCW_STATUS_RST : flags_reg;
    flags_next = flags_next | flags_set;
    if (trim_load) begin
      flags_next[`RCW_BIT_TRIM_ABN] = trim_rd_bad;
    end
  end

  // any reset drops a pending clear before it can commit
  always_comb begin
    fclr_next = fclr_reg;
    if (wr_status && hwdata[`RCW_BIT_FCLR]) begin
      fclr_next = 1'b1;
    end
    if (commit || rst_any) begin
      fclr_next = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= `RCW_STATUS_RST;
      fclr_reg <= 1'b0;
    end else if (clk_en) begin
      flags_reg <= flags_next;
      fclr_reg <= fclr_next;
    end
  end

  // ************************************************************
  // own control registers
  // ************************************************************
  logic vdet_en_reg;
  // internal requests leave the detector enable alone

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vdet_en_reg <= 1'b0;
      wulen_reg <= `RCW_WULEN_RST;
    end else if (clk_en) begin
      if (pin_rst) begin
        vdet_en_reg <= 1'b0;
      end else if (wr_ctrl) begin
        vdet_en_reg <= hwdata[0];
      end
      if (wr_wulen) begin
        wulen_reg <= hwdata[15:0];
      end
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [31:0] rd_status;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_wulen;
  logic [31:0] rd_seq;

  // bit 7 is write-only and reads zero
  assign rd_status = {24'h000000, 1'b0, flags_reg};
  assign rd_ctrl = {31'h00000000, vdet_en_reg};
  assign rd_wulen = {16'h0000, wulen_reg};
  assign rd_seq = {16'h0000, trim_data, 5'h00, trim_done_reg, state_reg};

  always_comb begin
    if (hit_status) begin
      hrdata = rd_status;
    end else if (hit_ctrl) begin
      hrdata = rd_ctrl;
    end else if (hit_wulen) begin
      hrdata = rd_wulen;
    end else if (hit_seq) begin
      hrdata = rd_seq;
    end else begin
      hrdata = 32'h00000000;
    end
  end

  // ************************************************************
  // cpu and peripheral start-up state
  // ************************************************************
  // registered so the start-up controls cannot glitch between states
  logic run_reg;
  logic run_next;
  logic hold_reg;
  logic hold_next;

  assign run_next = (state_next == RCW_RUN);
  assign hold_next = ~run_next | warm_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 1'b0;
      hold_reg <= 1'b1;
    end else if (clk_en) begin
      run_reg <= run_next;
      hold_reg <= hold_next;
    end
  end

  assign run = run_reg;
  assign cpu_rst_n = run;
  assign periph_rst_n = run;
  assign cpu_start = start_reg;
  assign cpu_init.program_counter = `RCW_RESET_VECTOR;
  assign cpu_init.stack_pointer = `RCW_SP_INIT;
  assign cpu_init.register_bank_select = 1'b0;
  assign cpu_init.interrupt_master_enable = 1'b0;
  assign cpu_init.irq_enable_clr = hold_reg;
  assign cpu_init.irq_latch_clr = hold_reg;
  assign hf_osc_force_en = hold_reg;
  assign lf_osc_force_dis = hold_reg;
  assign tg_clear = ~run;
  assign port_hiz = hold_reg;
  assign watchdog_en = run;
  assign vdet_en = vdet_en_reg;

endmodule : rcw_sequencer

// ---- verif/rcw_trim_model.sv ----
// trimming store model for the reset sequencer
// assumes the request is held until an edge with valid
`timescale 1ns/100ps
// ****
// trim store
// ****
module rcw_trim_model #(
  parameter logic [7:0] TRIM_VAL = 8'hA5
) (
  input wire logic hclk,
  input wire logic trim_rd_req,
  input wire logic [3:0] dly,
  input wire logic bad_mode,
  output logic trim_rd_valid,
  output logic [7:0] trim_rd_data,
  output logic trim_rd_bad
);
  logic [3:0] wait_reg = 4'h0;
  logic [7:0] junk_reg = 8'h00;
  always_ff @(posedge hclk) begin
    wait_reg <= trim_rd_req ? wait_reg + 4'h1 : 4'h0;
    junk_reg <= junk_reg + 8'h5B;
  end
  // answer after dly cycles, junk outside
  assign trim_rd_valid = trim_rd_req && wait_reg >= dly;
  assign trim_rd_data = trim_rd_valid ? TRIM_VAL : junk_reg;
  assign trim_rd_bad = trim_rd_valid ? bad_mode : junk_reg[0];
endmodule : rcw_trim_model

// ---- verif/rcw_sequencer_properties.sv ----
// port checker of the reset sequencer
// assumes the design ports of rcw_sequencer
`timescale 1ns/100ps
`include "rcw_map.svh"
// ****
// checker
// ****
module rcw_sequencer_chk
  import rcw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic ext_rst_n,
  input wire rcw_req_t rst_req,
  input wire logic trim_rd_req,
  input wire logic trim_rd_valid,
  input wire logic [7:0] trim_rd_data,
  input wire logic [7:0] trim_data,
  input wire logic cpu_rst_n,
  input wire logic periph_rst_n,
  input wire logic cpu_start,
  input wire rcw_cpu_init_t cpu_init,
  input wire logic hf_osc_force_en,
  input wire logic lf_osc_force_dis,
  input wire logic tg_clear,
  input wire logic port_hiz,
  input wire logic watchdog_en,
  input wire logic vdet_en
);
  logic rd_reg;
  logic [31:0] ad_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 1'b0;
      ad_reg <= 32'h0;
    end else begin
      rd_reg <= hsel && hready && htrans == `RCW_HTRANS_NONSEQ && !hwrite;
      ad_reg <= haddr;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_fclr;
    rd_reg && ad_reg == {18'h0, `RCW_IDX_STATUS, 2'h0} |-> !hrdata[`RCW_BIT_FCLR];
  endproperty
  a_fclr: assert property (p_fclr) else $error("clear bit read high");
  property p_run;
    cpu_rst_n |-> watchdog_en && !tg_clear && periph_rst_n;
  endproperty
  a_run: assert property (p_run) else $error("run outputs wrong");
  property p_hold;
    !cpu_rst_n |-> !watchdog_en && tg_clear && port_hiz && !periph_rst_n;
  endproperty
  a_hold: assert property (p_hold) else $error("reset outputs wrong");
  property p_pulse;
    cpu_start |=> !cpu_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_start;
    $rose(cpu_rst_n) |-> cpu_start;
  endproperty
  a_start: assert property (p_start) else $error("no start at release");
  property p_init;
    !cpu_rst_n || cpu_start |-> cpu_init.program_counter == `RCW_RESET_VECTOR &&
      cpu_init.stack_pointer == `RCW_SP_INIT && !cpu_init.register_bank_select &&
      !cpu_init.interrupt_master_enable;
  endproperty
  a_init: assert property (p_init) else $error("cpu init wrong");
  property p_osc;
    !cpu_rst_n || cpu_start |-> hf_osc_force_en && lf_osc_force_dis &&
      cpu_init.irq_enable_clr && cpu_init.irq_latch_clr;
  endproperty
  a_osc: assert property (p_osc) else $error("osc or irq clear wrong");
  property p_trim;
    trim_rd_req && trim_rd_valid |=> trim_data == $past(trim_rd_data) && !cpu_rst_n;
  endproperty
  a_trim: assert property (p_trim) else $error("trim not latched");
  property p_req;
    (rst_req != 6'h00) [*3] |=> !cpu_rst_n;
  endproperty
  a_req: assert property (p_req) else $error("request not reset");
  property p_pin;
    !ext_rst_n [*3] |=> !vdet_en;
  endproperty
  a_pin: assert property (p_pin) else $error("pin kept detector");
endmodule : rcw_sequencer_chk
bind rcw_sequencer rcw_sequencer_chk u_chk (.*);

// ---- verif/tb_top.sv ----
// register-level testbench of the reset sequencer
// assumes rcw_sequencer, rcw_trim_model and the checker
`timescale 1ns/100ps
`include "rcw_map.svh"
module tb_top
  import rcw_pkg::*;
;
  logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0, ext_rst_n = 1, bad_mode = 0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] dly = 4'h0;
  rcw_req_t rst_req = 6'h00;
  logic hready, hreadyout, hresp, trim_rd_req, trim_rd_valid, trim_rd_bad, cpu_rst_n;
  logic periph_rst_n, cpu_start, hf_osc_force_en, lf_osc_force_dis, tg_clear, port_hiz;
  logic watchdog_en, vdet_en;
  logic [7:0] trim_rd_data, trim_data;
  rcw_cpu_init_t cpu_init;
  int n_errors = 0, samples_checked = 0;
  assign hready = hreadyout;
  rcw_sequencer DUT (.*);
  rcw_trim_model TM (.*);
  always #5 hclk = ~hclk;
  // ****
  // tasks
  // ****
  task close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task bump(input bit t);
    if (t) begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  endtask : bump
  task edge_rdy;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    bump(n >= 50);
  endtask : edge_rdy
  task xfer(input logic w, input logic [11:0] ix, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= `RCW_HTRANS_NONSEQ;
    haddr <= {18'h0, ix, 2'h0};
    hwrite <= w;
    hsize <= `RCW_HSIZE_WORD;
    edge_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    edge_rdy();
    r = hrdata;
    chk({31'h00000000, hresp}, 32'h00000000);
  endtask : xfer
  task wr(input logic [11:0] ix, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, ix, d, r);
  endtask : wr
  task rc(input logic [11:0] ix, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, ix, 32'h0, r);
    chk(r, e);
  endtask : rc
  task wait_run(output int n);
    n = 0;
    do begin @(posedge hclk); n++; #1; end while (cpu_start !== 1'b1 && n < 3000);
    bump(n >= 3000);
    @(posedge hclk);
  endtask : wait_run
  task hit(input int i, input bit w);
    int n;
    rst_req <= rcw_req_t'(6'h01 << i);
    repeat (4) @(posedge hclk);
    rst_req <= 6'h00;
    if (w) wait_run(n);
  endtask : hit
  // ****
  // sequence
  // ****
  initial begin
    int n;
    logic [6:0] ex;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    wait_run(n);
    chk({31'h00000000, n >= `RCW_WULEN_RST}, 32'h00000001);
    chk(trim_data, 32'h000000A5);
    rc(`RCW_IDX_SEQSTAT, 32'h0000A506);
    rc(`RCW_IDX_STATUS, 32'h00000000);
    wr(`RCW_IDX_WULEN, 32'h00000010);
    wr(`RCW_IDX_CTRL, 32'h00000001);
    ex = 7'h00;
    for (int i = 0; i < 6; i++) begin
      hit(i, 1'b1);
      ex[i == 5 ? 6 : i] = 1'b1;
      rc(`RCW_IDX_STATUS, {25'h0000000, ex});
    end
    rc(`RCW_IDX_CTRL, 32'h00000001);
    hit(0, 1'b0);
    repeat (8) @(posedge hclk);
    hit(0, 1'b0);
    wait_run(n);
    chk({31'h00000000, n >= 18}, 32'h00000001);
    wr(`RCW_IDX_PROTECT, 32'h00000071);
    rc(`RCW_IDX_STATUS, {25'h0000000, ex});
    wr(`RCW_IDX_STATUS, 32'h00000080);
    rc(`RCW_IDX_STATUS, {25'h0000000, ex});
    wr(`RCW_IDX_PROTECT, 32'h00000055);
    rc(`RCW_IDX_STATUS, {25'h0000000, ex});
    hit(1, 1'b1);
    wr(`RCW_IDX_PROTECT, 32'h00000071);
    rc(`RCW_IDX_STATUS, {25'h0000000, ex});
    wr(`RCW_IDX_STATUS, 32'h0000007F);
    rc(`RCW_IDX_STATUS, {25'h0000000, ex});
    wr(`RCW_IDX_STATUS, 32'h00000080);
    wr(`RCW_IDX_PROTECT, 32'h00000071);
    rc(`RCW_IDX_STATUS, 32'h00000000);
    bad_mode <= 1'b1;
    dly <= 4'h9;
    hit(1, 1'b1);
    rc(`RCW_IDX_STATUS, 32'h00000022);
    bad_mode <= 1'b0;
    hit(1, 1'b1);
    rc(`RCW_IDX_STATUS, 32'h00000002);
    ext_rst_n <= 1'b0;
    repeat (4) @(posedge hclk);
    ext_rst_n <= 1'b1;
    wait_run(n);
    rc(`RCW_IDX_STATUS, 32'h00000000);
    rc(`RCW_IDX_CTRL, 32'h00000000);
    close_out();
  end
endmodule : tb_top
